// ==== core/motion_pkg.sv ====
// Shared constants, command word layout and state types of the motion command sequencer
// Operation
// - Continuous move steps without distance limit in the set direction up to run speed.
// - With an accel ramp, start at start speed and rise at the accel rate.
// - Accel rate zero starts the move directly at run speed.
// - With a decel ramp, fall from run speed to end speed at the decel rate.
// - Decel rate zero ends the move at run speed, stepping stops at once.
// - Moving uses run current; boost adds 30 percent during ramps, at most 300 ms.
// - After the last step wait the delay time, then switch to hold current.
// - Continuous move and stop apply their own step resolution; emergency stop keeps the previous one.
// - Stop ramps the actuator to rest and the program carries on.
// - Stop uses decel current, boosted by 30 percent for at most 300 ms if enabled.
// - Emergency stop halts stepping at once, decel then hold current, program continues.
// - Counted jump goes to its target on its first N executions, then falls through.
// - Unconditional jump always goes to its target.
// - Exit to label clears all counted-jump progress and goes to its target.
package motion_pkg;
    localparam int CLK_HZ    = 40_000_000;
    localparam int MS_PER_S  = 1000;
    localparam int BOOST_MS  = 300;
    localparam int MS_CYC    = CLK_HZ / MS_PER_S;
    localparam int BOOST_CYC = MS_CYC * BOOST_MS;
    localparam int BOOST_PCT = 30;
    localparam int PCT_FULL  = 100;

    localparam int SPD_W  = 12;
    localparam int CUR_W  = 8;
    localparam int LBL_W  = 8;
    localparam int CNT_W  = 8;
    localparam int RATE_W = 8;
    localparam int DLY_W  = 12;
    localparam int ADR_W  = 4;

    localparam logic [ADR_W-1:0] ADDR_CTRL  = 4'h0;
    localparam logic [ADR_W-1:0] ADDR_STAT  = 4'h4;
    localparam logic [ADR_W-1:0] ADDR_SPEED = 4'h8;
    localparam int CTRL_RUN    = 0;
    localparam int CTRL_PC_LSB = 8;
    localparam int STAT_RUN    = 0;
    localparam int STAT_MOVE   = 1;
    localparam int STAT_MOT    = 4;
    localparam int STAT_PC     = 8;

    typedef enum logic [2:0] {
        OP_END       = 3'h0,
        OP_CONT_MOVE = 3'h1,
        OP_STOP      = 3'h2,
        OP_ESTOP     = 3'h3,
        OP_JUMP_N    = 3'h4,
        OP_JUMP      = 3'h5,
        OP_EXIT_SUB  = 3'h6
    } op_e;

    typedef enum logic [1:0] {
        SEQ_IDLE  = 2'h0,
        SEQ_FETCH = 2'h1,
        SEQ_EXEC  = 2'h3
    } seq_e;

    typedef enum logic [2:0] {
        MOT_IDLE  = 3'h0,
        MOT_ACCEL = 3'h1,
        MOT_RUN   = 3'h3,
        MOT_DECEL = 3'h2,
        MOT_DELAY = 3'h6
    } mot_e;

    typedef struct packed {
        op_e               op;
        logic              dir;
        logic [2:0]        stepMode;
        logic              accBoost;
        logic              decBoost;
        logic [LBL_W-1:0]  target;
        logic [CNT_W-1:0]  count;
        logic [SPD_W-1:0]  runSpd;
        logic [SPD_W-1:0]  startSpd;
        logic [SPD_W-1:0]  endSpd;
        logic [RATE_W-1:0] accRate;
        logic [RATE_W-1:0] decRate;
        logic [CUR_W-1:0]  runCur;
        logic [CUR_W-1:0]  holdCur;
        logic [DLY_W-1:0]  delayMs;
    } cmd_s;

    typedef struct packed {
        logic             step;
        logic             dir;
        logic [2:0]       stepMode;
        logic [CUR_W:0]   current;
    } drive_s;

    typedef struct packed {
        logic [ADR_W-1:0] addr;
        logic [31:0]      wdata;
        logic             wr;
        logic             rd;
    } busReq_s;

    function automatic logic [CUR_W:0] boostCur(input logic [CUR_W-1:0] c, input logic on);
        logic [CUR_W+7:0] p;
        p = (CUR_W+8)'(c) * (CUR_W+8)'(PCT_FULL + BOOST_PCT) / (CUR_W+8)'(PCT_FULL);
        return on ? p[CUR_W:0] : {1'b0, c};
    endfunction : boostCur
endpackage : motion_pkg

// ==== core/speed_ramp.sv ====
// Step rate ramp and step pulse generator
`timescale 1ns/1ps
`default_nettype none
module speed_ramp import motion_pkg::*; #(
    parameter int ACC_W = 24
) (
    input  wire logic              ref_clk,  // System clock
    input  wire logic              rst_n,    // Synchronous reset
    input  wire logic              load,     // Load speed now
    input  wire logic              run,      // Stepping allowed
    input  wire logic              tick,     // Ramp update strobe
    input  wire logic [SPD_W-1:0]  loadSpd,  // Speed to load
    input  wire logic [SPD_W-1:0]  target,   // Speed to ramp toward
    input  wire logic [RATE_W-1:0] rate,     // Speed change per tick
    output logic                   step,     // One-cycle step pulse
    output logic [SPD_W-1:0]       speed,    // Present speed
    output logic                   atTarget  // Speed equals target
);
    typedef struct packed {
        logic [SPD_W-1:0] spd;
        logic [ACC_W-1:0] acc;
        logic             step;
    } ramp_s;

    ramp_s r, n;

    if (ACC_W <= SPD_W) begin : g_chk
        $error("ACC_W must exceed the speed width");
    end

    always_comb begin
        n = r;
        n.step = 1'b0;
        if (load) begin
            n.spd = loadSpd;
        end else if (tick && r.spd < target) begin
            n.spd = (target - r.spd > SPD_W'(rate)) ? r.spd + SPD_W'(rate) : target;
        end else if (tick && r.spd > target) begin
            n.spd = (r.spd - target > SPD_W'(rate)) ? r.spd - SPD_W'(rate) : target;
        end
        // Phase accumulator: carry out is the step, so step rate tracks speed linearly
        if (run && !load) begin
            {n.step, n.acc} = {1'b0, r.acc} + (ACC_W+1)'(r.spd);
        end else begin
            n.acc = '0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign step     = r.step;
    assign speed    = r.spd;
    assign atTarget = (r.spd == target);
endmodule : speed_ramp
`default_nettype wire

// ==== core/jump_counters.sv ====
// Remaining-jump counters for counted jumps, one per program line
`timescale 1ns/1ps
`default_nettype none
module jump_counters import motion_pkg::*; #(
    parameter int DEPTH = 256
) (
    input  wire logic             ref_clk,  // System clock
    input  wire logic             rst_n,    // Synchronous reset
    input  wire logic             exec,     // Counted jump executes
    input  wire logic             clearAll, // Forget all progress
    input  wire logic [LBL_W-1:0] line,     // Line of the command
    input  wire logic [CNT_W-1:0] count,    // Programmed jump count
    output logic                  taken     // Jump is taken
);
    typedef struct packed {
        logic [DEPTH-1:0]            live;
        logic [DEPTH-1:0][CNT_W-1:0] left;
    } jc_s;

    jc_s              r, n;
    logic [CNT_W-1:0] eff;

    if (DEPTH != (1 << LBL_W)) begin : g_chk
        $error("DEPTH must cover every program line");
    end

    always_comb begin
        n = r;
        eff = r.live[line] ? r.left[line] : count;
        taken = (eff != '0);
        if (clearAll) begin
            n.live = '0;
        end else if (exec) begin
            if (taken) begin
                n.left[line] = eff - 1'b1;
                n.live[line] = 1'b1;
            end else begin
                n.live[line] = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_fresh_jump_taken: assert property (
        exec && !clearAll && !r.live[line] && count != '0 |-> taken ##1 r.live[$past(line)])
        else $error("Fresh counted jump not taken");
    a_reload_after_fall: assert property (
        exec && !clearAll && !taken |=> !r.live[$past(line)])
        else $error("Counted jump not reloaded after falling through");
    a_clear_all_progress: assert property (
        clearAll |=> r.live == '0)
        else $error("Counted jump progress not cleared");
endmodule : jump_counters
`default_nettype wire

// ==== core/motion_command_sequencer.sv ====
// Motion program command interpreter driving a stepper phase driver
`timescale 1ns/1ps
`default_nettype none
module motion_command_sequencer import motion_pkg::*; #(
    parameter int MS_CYCLES    = MS_CYC,
    parameter int BOOST_CYCLES = BOOST_CYC,
    parameter int ACC_W        = 24
) (
    input  wire logic    ref_clk,   // 40 MHz system clock
    input  wire logic    rst_n,     // Synchronous reset
    input  wire busReq_s busReq,    // Register port request
    output logic [31:0]  busRdata,  // Read data, cycle after read
    output logic [LBL_W-1:0] progAddr, // Program store line
    input  wire cmd_s    progData,  // Command word, cycle after address
    output drive_s       drive      // Phase driver command
);
    localparam int MS_W    = 16;
    localparam int BOOST_W = 24;

    if (MS_CYCLES < 2 || MS_CYCLES > (1 << MS_W) || BOOST_CYCLES < 1
        || BOOST_CYCLES >= (1 << BOOST_W)) begin : g_chk
        $error("Timing counts out of range");
    end

    typedef struct packed {
        seq_e              seq;
        mot_e              mot;
        logic              running;
        logic [LBL_W-1:0]  pc;
        logic [CUR_W-1:0]  runCur;
        logic [CUR_W-1:0]  holdCur;
        logic [DLY_W-1:0]  dlyMs;
        logic [DLY_W-1:0]  msLeft;
        logic [SPD_W-1:0]  tgt;
        logic [RATE_W-1:0] rate;
        logic              boostOn;
        logic [BOOST_W-1:0] boostCnt;
        logic [MS_W-1:0]   msCnt;
        drive_s            drv;
        logic [31:0]       rdata;
    } top_s;

    top_s              s, n;
    logic              msTick;
    logic              exec;
    logic              rampLoad;
    logic [SPD_W-1:0]  rampLoadSpd;
    logic              rampStep;
    logic [SPD_W-1:0]  rampSpeed;
    logic              rampAt;
    logic              jumpExec;
    logic              jumpClear;
    logic              jumpTaken;

    function automatic logic isStepping(input mot_e m);
        return (m == MOT_ACCEL) || (m == MOT_RUN) || (m == MOT_DECEL);
    endfunction : isStepping

    assign msTick = (s.msCnt == MS_W'(MS_CYCLES - 1));
    assign exec   = (s.seq == SEQ_EXEC);

    speed_ramp #(
        .ACC_W(ACC_W)
    ) u_ramp (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .load    (rampLoad),
        .run     (isStepping(s.mot)),
        .tick    (msTick),
        .loadSpd (rampLoadSpd),
        .target  (s.tgt),
        .rate    (s.rate),
        .step    (rampStep),
        .speed   (rampSpeed),
        .atTarget(rampAt)
    );

    jump_counters #(
        .DEPTH(1 << LBL_W)
    ) u_jumps (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .exec    (jumpExec),
        .clearAll(jumpClear),
        .line    (s.pc),
        .count   (progData.count),
        .taken   (jumpTaken)
    );

    always_comb begin
        n = s;
        rampLoad = 1'b0;
        rampLoadSpd = '0;
        jumpExec = 1'b0;
        jumpClear = 1'b0;
        n.msCnt = msTick ? '0 : s.msCnt + 1'b1;

        // Boost ends on its own once the ceiling runs out, even mid-ramp
        if (s.boostOn) begin
            if (s.boostCnt == BOOST_W'(BOOST_CYCLES - 1)) begin
                n.boostOn = 1'b0;
            end else begin
                n.boostCnt = s.boostCnt + 1'b1;
            end
        end

        unique case (s.mot)
            MOT_ACCEL: if (rampAt) begin
                n.mot = MOT_RUN;
                n.boostOn = 1'b0;
            end
            MOT_DECEL: if (rampAt) begin
                n.mot = MOT_DELAY;
                n.boostOn = 1'b0;
                n.msLeft = s.dlyMs;
                n.msCnt = '0;
            end
            MOT_DELAY: if (msTick) begin
                if (s.msLeft <= DLY_W'(1)) begin
                    n.mot = MOT_IDLE;
                end else begin
                    n.msLeft = s.msLeft - 1'b1;
                end
            end
            MOT_IDLE, MOT_RUN: ;
            default: n.mot = MOT_IDLE;
        endcase

        unique case (s.seq)
            SEQ_IDLE: if (s.running) begin
                n.seq = SEQ_FETCH;
            end
            SEQ_FETCH: n.seq = SEQ_EXEC;
            SEQ_EXEC: begin
                n.seq = SEQ_FETCH;
                n.pc = s.pc + 1'b1;
                case (progData.op)
                    OP_CONT_MOVE: begin
                        n.drv.dir = progData.dir;
                        n.drv.stepMode = progData.stepMode;
                        n.runCur = progData.runCur;
                        n.holdCur = progData.holdCur;
                        n.dlyMs = progData.delayMs;
                        n.tgt = progData.runSpd;
                        n.rate = progData.accRate;
                        rampLoad = 1'b1;
                        if (progData.accRate == '0) begin
                            rampLoadSpd = progData.runSpd;
                            n.mot = MOT_RUN;
                            n.boostOn = 1'b0;
                        end else begin
                            rampLoadSpd = progData.startSpd;
                            n.mot = MOT_ACCEL;
                            n.boostOn = progData.accBoost;
                            n.boostCnt = '0;
                        end
                    end
                    OP_STOP: begin
                        n.runCur = progData.runCur;
                        n.holdCur = progData.holdCur;
                        n.dlyMs = progData.delayMs;
                        n.drv.stepMode = progData.stepMode;
                        if (isStepping(s.mot) && progData.decRate != '0) begin
                            n.tgt = progData.endSpd;
                            n.rate = progData.decRate;
                            n.mot = MOT_DECEL;
                            n.boostOn = progData.decBoost;
                            n.boostCnt = '0;
                        end else begin
                            n.mot = MOT_DELAY;
                            n.boostOn = 1'b0;
                            n.msLeft = progData.delayMs;
                            n.msCnt = '0;
                        end
                    end
                    OP_ESTOP: begin
                        n.runCur = progData.runCur;
                        n.holdCur = progData.holdCur;
                        n.dlyMs = progData.delayMs;
                        n.mot = MOT_DELAY;
                        n.boostOn = 1'b0;
                        n.msLeft = progData.delayMs;
                        n.msCnt = '0;
                    end
                    OP_JUMP_N: begin
                        jumpExec = 1'b1;
                        if (jumpTaken) begin
                            n.pc = progData.target;
                        end
                    end
                    OP_JUMP: n.pc = progData.target;
                    OP_EXIT_SUB: begin
                        jumpClear = 1'b1;
                        n.pc = progData.target;
                    end
                    default: begin
                        n.running = 1'b0;
                        n.seq = SEQ_IDLE;
                        n.pc = s.pc;
                    end
                endcase
            end
            default: n.seq = SEQ_IDLE;
        endcase

        // An end-of-program wins over a software start in the same cycle, as start is ignored while running
        if (busReq.wr && busReq.addr == ADDR_CTRL) begin
            if (!busReq.wdata[CTRL_RUN]) begin
                n.running = 1'b0;
                n.seq = SEQ_IDLE;
            end else if (!s.running) begin
                n.running = 1'b1;
                n.seq = SEQ_IDLE;
                n.pc = busReq.wdata[CTRL_PC_LSB +: LBL_W];
            end
        end

        n.drv.step = rampStep;
        if (n.mot == MOT_IDLE) begin
            n.drv.current = {1'b0, n.holdCur};
        end else begin
            n.drv.current = boostCur(n.runCur, n.boostOn);
        end

        n.rdata = '0;
        if (busReq.rd) begin
            case (busReq.addr)
                ADDR_CTRL: begin
                    n.rdata[CTRL_RUN] = s.running;
                    n.rdata[CTRL_PC_LSB +: LBL_W] = s.pc;
                end
                ADDR_STAT: begin
                    n.rdata[STAT_RUN] = s.running;
                    n.rdata[STAT_MOVE] = isStepping(s.mot);
                    n.rdata[STAT_MOT +: 3] = s.mot;
                    n.rdata[STAT_PC +: LBL_W] = s.pc;
                end
                ADDR_SPEED: n.rdata[SPD_W-1:0] = rampSpeed;
                default: n.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign busRdata = s.rdata;
    assign progAddr = s.pc;
    assign drive    = s.drv;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_cont_direction: assert property (
        exec && progData.op == OP_CONT_MOVE |=> drive.dir == $past(progData.dir)
            && isStepping(s.mot) && s.tgt == $past(progData.runSpd))
        else $error("Continuous move did not start in its direction");
    a_accel_start_speed: assert property (
        exec && progData.op == OP_CONT_MOVE && progData.accRate != '0
            |=> s.mot == MOT_ACCEL && rampSpeed == $past(progData.startSpd))
        else $error("Accel ramp did not start at start speed");
    a_no_accel_run: assert property (
        exec && progData.op == OP_CONT_MOVE && progData.accRate == '0
            |=> s.mot == MOT_RUN && rampSpeed == $past(progData.runSpd))
        else $error("Zero accel did not start at run speed");
    a_decel_ramp_entry: assert property (
        exec && progData.op == OP_STOP && progData.decRate != '0 && isStepping(s.mot)
            |=> s.mot == MOT_DECEL && s.tgt == $past(progData.endSpd))
        else $error("Stop did not ramp toward end speed");
    a_no_decel_halt: assert property (
        exec && progData.op == OP_STOP && progData.decRate == '0
            |=> s.mot == MOT_DELAY ##2 !drive.step)
        else $error("Zero decel kept stepping");
    a_boost_ceiling: assert property (
        s.boostOn |-> s.boostCnt < BOOST_W'(BOOST_CYCLES))
        else $error("Boost outlived its ceiling");
    a_hold_after_delay: assert property (
        s.mot == MOT_DELAY ##1 s.mot == MOT_IDLE |-> drive.current == {1'b0, s.holdCur})
        else $error("Hold current not applied after delay");
    a_step_resolution: assert property (
        exec && progData.op == OP_CONT_MOVE |=> drive.stepMode == $past(progData.stepMode))
        else $error("Step resolution not applied");
    a_stop_continues: assert property (
        exec && progData.op == OP_STOP && !busReq.wr
            |=> s.seq == SEQ_FETCH && s.pc == $past(s.pc) + 1'b1)
        else $error("Stop halted the program");
    a_decel_current: assert property (
        exec && progData.op == OP_STOP && progData.decRate != '0 && isStepping(s.mot)
            |=> drive.current == boostCur($past(progData.runCur), $past(progData.decBoost)))
        else $error("Stop current wrong");
    a_estop_immediate: assert property (
        exec && progData.op == OP_ESTOP
            |=> s.mot == MOT_DELAY && drive.current == {1'b0, $past(progData.runCur)})
        else $error("Emergency stop not immediate");
    a_jump_target: assert property (
        exec && progData.op == OP_JUMP && !busReq.wr |=> s.pc == $past(progData.target))
        else $error("Jump missed its target");
    a_exit_target: assert property (
        exec && progData.op == OP_EXIT_SUB && !busReq.wr |=> s.pc == $past(progData.target))
        else $error("Exit to label missed its target");
endmodule : motion_command_sequencer
`default_nettype wire

// ==== verif/prog_store_model.sv ====
// Program store and step-counting actuator on the far side of the sequencer
`timescale 1ns/1ps
`default_nettype none
module prog_store_model import motion_pkg::*; (
    input  wire logic             ref_clk,  // System clock
    input  wire logic             rst_n,    // Synchronous reset
    input  wire logic [LBL_W-1:0] progAddr, // Line asked for
    input  wire drive_s           drive,    // Phase driver command
    output var cmd_s              progData, // Word, one cycle later
    output var int                steps     // Step pulses seen
);
    cmd_s mem [256];

    // Synchronous read, as a block memory would answer
    always_ff @(posedge ref_clk) begin
        progData <= mem[progAddr];
        if (!rst_n) begin
            steps <= 0;
        end else if (drive.step === 1'b1) begin
            steps <= steps + 1;
        end
    end
endmodule : prog_store_model
`default_nettype wire

// ==== verif/motion_command_sequencer_bench.sv ====
// Self-checking bench for the motion command sequencer
`timescale 1ns/1ps
`default_nettype none
module motion_command_sequencer_bench import motion_pkg::*;;
    logic             ref_clk = 1'b0;
    logic             rst_n   = 1'b0;
    busReq_s          busReq  = '0;
    logic [31:0]      busRdata;
    logic [LBL_W-1:0] progAddr;
    cmd_s             progData;
    drive_s           drive;
    cmd_s             c;
    cmd_s             cs;
    int               steps;
    int               st;
    int               errors = 0;
    int               checks = 0;
    int               pcq [$];
    op_e              stp [2] = '{OP_STOP, OP_ESTOP};

    // Short ms tick and boost limit keep ramps and holds within a few hundred cycles
    motion_command_sequencer #(.MS_CYCLES(4), .BOOST_CYCLES(50), .ACC_W(13)) i_dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .busReq(busReq), .busRdata(busRdata),
        .progAddr(progAddr), .progData(progData), .drive(drive));
    prog_store_model i_store (.ref_clk(ref_clk), .rst_n(rst_n), .progAddr(progAddr),
        .drive(drive), .progData(progData), .steps(steps));

    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cyc

    task automatic bus(input logic [3:0] a, input logic [31:0] d, input logic w);
        @(posedge ref_clk);
        busReq <= '{addr: a, wdata: d, wr: w, rd: ~w};
        @(posedge ref_clk);
        busReq <= '0;
        #1;
    endtask : bus

    task automatic do_reset();
        @(posedge ref_clk);
        rst_n <= 1'b0;
        cyc(7);
        chk("resetOut", busRdata | 32'({progAddr, drive}), 32'h0);
        // Release on the edge so the first request lands one cycle after reset ends
        @(posedge ref_clk);
        rst_n <= 1'b1;
    endtask : do_reset

    task automatic close_out();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out

    // Reference interpreter: expected line order for n executed commands after a start
    function automatic void model_run(input int n);
        int   pc = 0;
        int   done [256];
        cmd_s w;
        pcq = {};
        for (int i = 0; i < n; i++) begin
            w = i_store.mem[pc];
            pcq.push_back(pc);
            case (w.op)
                OP_JUMP: pc = w.target;
                OP_EXIT_SUB: begin
                    foreach (done[j]) done[j] = 0;
                    pc = w.target;
                end
                OP_JUMP_N: begin
                    if (done[pc] < w.count) begin
                        done[pc]++;
                        pc = w.target;
                    end else begin
                        done[pc] = 0;
                        pc = (pc + 1) % 256;
                    end
                end
                default: pc = (pc + 1) % 256;
            endcase
        end
    endfunction : model_run

    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        close_out();
    end

    initial begin
        void'($urandom(25846));
        c = '0;
        c.op = OP_JUMP;
        foreach (i_store.mem[i]) i_store.mem[i] = c;
        do_reset();
        bus(4'hc, 32'h0, 1'b0);
        chk("unmapped", busRdata, 32'h0);
        for (int t = 0; t < 20; t++) begin
            for (int i = 0; i < 8; i++) begin
                c = '0;
                c.op = op_e'(3'h4 + 3'($urandom % 3));
                c.target = 8'($urandom % 8);
                c.count = 8'($urandom % 4);
                i_store.mem[i] = c;
            end
            model_run(24);
            do_reset();
            bus(ADDR_CTRL, 32'h1, 1'b1);
            foreach (pcq[i]) begin
                cyc(2);
                chk("progAddr", 32'(progAddr), 32'(pcq[i]));
            end
        end
        foreach (stp[k]) begin
            c = '0;
            c.op = OP_CONT_MOVE;
            c.dir = 1'($urandom);
            c.stepMode = 3'($urandom);
            c.runSpd = 12'h800;
            c.runCur = 8'($urandom);
            i_store.mem[0] = c;
            i_store.mem[1] = '{op: OP_JUMP_N, target: 8'h1, count: 8'd15, default: '0};
            cs = '0;
            cs.op = stp[k];
            cs.endSpd = 12'h7e0;
            cs.decRate = 8'h1;
            cs.decBoost = 1'b1;
            cs.runCur = 8'($urandom);
            cs.holdCur = 8'($urandom);
            cs.delayMs = 12'h1;
            i_store.mem[2] = cs;
            i_store.mem[3] = '{op: OP_JUMP, target: 8'h3, default: '0};
            do_reset();
            bus(ADDR_CTRL, 32'h1, 1'b1);
            cyc(10);
            chk("dirMode", 32'({drive.dir, drive.stepMode}), 32'({c.dir, c.stepMode}));
            chk("runCur", 32'(drive.current), 32'(c.runCur));
            bus(ADDR_SPEED, 32'h0, 1'b0);
            chk("speed", busRdata, 32'h800);
            chk("stepping", 32'(steps > 0), 32'h1);
            bus(ADDR_STAT, 32'h0, 1'b0);
            chk("status", busRdata, (32'h1 << STAT_RUN) | (32'h1 << STAT_MOVE)
                | (32'(MOT_RUN) << STAT_MOT) | (32'h1 << STAT_PC));
            cyc(25);
            chk("decelCur", 32'(drive.current),
                32'(k == 0 ? int'(cs.runCur) * 130 / 100 : int'(cs.runCur)));
            cyc(3);
            st = steps;
            cyc(20);
            chk("stepsAfterStop", 32'(steps > st), 32'(k == 0));
            cyc(33);
            chk("boostEnd", 32'(drive.current), 32'(k == 0 ? cs.runCur : cs.holdCur));
            cyc(120);
            chk("holdCur", 32'(drive.current), 32'(cs.holdCur));
            chk("programOn", 32'(progAddr), 32'h3);
        end
        // Ramped start with accel boost, then an end of program while still accelerating
        c = '0;
        c.op = OP_CONT_MOVE;
        c.runSpd = 12'h800;
        c.startSpd = 12'h700;
        c.accRate = 8'h1;
        c.accBoost = 1'b1;
        c.runCur = 8'($urandom);
        i_store.mem[0] = c;
        i_store.mem[1] = '0;
        do_reset();
        bus(ADDR_CTRL, 32'h1, 1'b1);
        cyc(2);
        bus(ADDR_SPEED, 32'h0, 1'b0);
        chk("startSpeed", busRdata, 32'h700);
        chk("accelCur", 32'(drive.current),
            32'(int'(c.runCur) * (PCT_FULL + BOOST_PCT) / PCT_FULL));
        bus(ADDR_STAT, 32'h0, 1'b0);
        chk("endStatus", busRdata, (32'h1 << STAT_MOVE)
            | (32'(MOT_ACCEL) << STAT_MOT) | (32'h1 << STAT_PC));
        bus(ADDR_CTRL, 32'h0, 1'b0);
        chk("ctrl", busRdata, 32'h1 << CTRL_PC_LSB);
        close_out();
    end
endmodule : motion_command_sequencer_bench
`default_nettype wire
